// ==== tb/tpw_pin_model.sv ====
// Load on the compare pin: pull-down when released, measures pulses.
// Assumes the bench clock and reset; counts in clock cycles.
module tpw_pin_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Pin as seen by the load
	input  wire logic pin,
	input  wire logic oe,
	output logic      level,
	output int        rises,
	output int        period,
	output int        high
);
	timeunit 1ns;
	timeprecision 1ps;
	int   age;
	logic prev;
	// Released pin sinks to the pull-down
	assign level = oe ? pin : 1'b0;
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			age <= 0;
			prev <= 1'b0;
			rises <= 0;
			period <= 0;
			high <= 0;
		end
		else
		begin
			prev <= level;
			age <= age + 1;
			if (level && !prev)
			begin
				rises <= rises + 1;
				period <= age;
				age <= 1;
			end
			if (!level && prev)
				high <= age;
		end
	end
endmodule : tpw_pin_model

// ==== tb/tpw_timer_assertions.sv ====
// Port-level checker for the timer block.
// Assumes binding onto tpw_timer, one clock, RST_B async active low.
module tpw_timer_assertions (
	// Clock and reset
	input wire logic        CLK_SYS,
	input wire logic        RST_B,
	// Bus
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic [7:0]  WB_ADR_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_ACK_O,
	// Pin, power and interrupt
	input wire logic        COMPARE_OUT_PIN_A,
	input wire logic        COMPARE_OUT_PIN_A_OE,
	input wire logic        CPU_IRQ_MASK,
	input wire logic        WAIT_MODE,
	input wire logic        HALT_MODE,
	input wire logic        TIMER_IRQ,
	input wire logic        WAIT_WAKE_REQ
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_B);
	a_ack_latency: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("ack late");
	a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack too long");
	a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
		else $error("ack without request");
	a_unmapped_zero: assert property (WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O
		&& WB_ADR_I == 8'h3c |=> WB_ACK_O && WB_DAT_O == 32'h0)
		else $error("unmapped read not zero");
	a_byte_wide: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
		else $error("read data wider than a byte");
	a_irq_masked: assert property (CPU_IRQ_MASK |-> !TIMER_IRQ)
		else $error("interrupt while masked");
	a_wake_gate: assert property (WAIT_WAKE_REQ == (TIMER_IRQ && WAIT_MODE && !HALT_MODE))
		else $error("wake request wrong");
	a_halt_steady: assert property (HALT_MODE [*3] |-> $stable(COMPARE_OUT_PIN_A))
		else $error("pin moved in halt");
	a_reset_quiet: assert property (disable iff (1'b0)
		!RST_B |-> !WB_ACK_O && !TIMER_IRQ && !COMPARE_OUT_PIN_A_OE)
		else $error("outputs active in reset");
	c_irq: cover property (TIMER_IRQ);
	c_wake: cover property (WAIT_WAKE_REQ);
	c_pin_rise: cover property ($rose(COMPARE_OUT_PIN_A));
endmodule : tpw_timer_assertions

bind tpw_timer tpw_timer_assertions tpw_timer_assertions_i (.CLK_SYS, .RST_B, .WB_CYC_I,
	.WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_O, .WB_ACK_O, .COMPARE_OUT_PIN_A,
	.COMPARE_OUT_PIN_A_OE, .CPU_IRQ_MASK, .WAIT_MODE, .HALT_MODE, .TIMER_IRQ,
	.WAIT_WAKE_REQ);

// ==== tb/tpw_timer_tb_top.sv ====
// Self-checking bench for the timer: bus, PWM output, flags, power.
// Assumes tpw_timer, tpw_pin_model and the bound checker are compiled.
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
	$display("BAD %0t %h %h", $time, (a), (e)); end end
module tpw_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst_b = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic        mask = 1'b0;
	logic        wt = 1'b0;
	logic        hlt = 1'b0;
	logic        cap_b = 1'b0;
	logic        cap_a = 1'b0;
	logic        ext = 1'b0;
	int          ext_n = 0;
	localparam int EXT_HALF = 3;
	logic [31:0] rdat;
	logic        ack, pin_a, pin_a_oe, irq, wake, lvl;
	logic [7:0]  q, v;
	int          num_errors = 0;
	int          checks_done = 0;
	int          c1, c2, st, rises, per, hi;
	logic [1:0]  codes [4] = '{tpw_pkg::CLK_DIV2, tpw_pkg::CLK_DIV4, tpw_pkg::CLK_DIV8,
		tpw_pkg::CLK_EXT};
	int          divs [4] = '{2, 4, 8, 2 * EXT_HALF};
	always #20 clk = ~clk;
	// Free-running external timer clock
	always @(posedge clk)
	begin
		ext_n <= (ext_n == EXT_HALF - 1) ? 0 : ext_n + 1;
		if (ext_n == EXT_HALF - 1)
			ext <= ~ext;
	end
	tpw_timer tpw_timer_i (.CLK_SYS(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .CAPTURE_IN_PIN_A(cap_a), .CAPTURE_IN_PIN_B(cap_b),
		.EXT_TIMER_CLK(ext), .COMPARE_OUT_PIN_A(pin_a), .COMPARE_OUT_PIN_A_OE(pin_a_oe),
		.COMPARE_OUT_PIN_B(), .COMPARE_OUT_PIN_B_OE(), .CPU_IRQ_MASK(mask),
		.WAIT_MODE(wt), .HALT_MODE(hlt), .TIMER_IRQ(irq), .WAIT_WAKE_REQ(wake));
	tpw_pin_model tpw_pin_model_i (.clk(clk), .rst_b(rst_b), .pin(pin_a), .oe(pin_a_oe),
		.level(lvl), .rises(rises), .period(per), .high(hi));
	function automatic int exp_period(input int div, input int b);
		return div * (b + 5);
	endfunction : exp_period
	function automatic int exp_high(input int div, input int a, input int b);
		return div * (b - a);
	endfunction : exp_high
	task automatic end_of_test;
		if (num_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] r);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 16);
		r = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1)
		begin
			num_errors++;
			end_of_test();
		end
	endtask : wb
	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		wb(1'b1, a, d[15:8], q);
		wb(1'b1, a + 8'h04, d[7:0], q);
	endtask : wr16
	task automatic wait_rises(input int n);
		int s, k;
		s = rises;
		k = 0;
		while (rises < s + n && k < 4000)
		begin
			@(posedge clk);
			k++;
		end
		if (k >= 4000)
		begin
			num_errors++;
			end_of_test();
		end
	endtask : wait_rises
	initial
	begin
		rst_b <= 1'b0;
		void'($urandom(32'hbd0ad80a));
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		wb(1'b0, tpw_pkg::OFS_CTRL_A, 8'h00, q);
		`CHK(q, tpw_pkg::RST_CTRL_A)
		v = 8'($urandom);
		wb(1'b1, tpw_pkg::OFS_CTRL_A, v, q);
		wb(1'b0, tpw_pkg::OFS_CTRL_A, 8'h00, q);
		`CHK(q, v)
		c2 = 24 + $urandom % 16;
		c1 = 4 + $urandom % 12;
		// Period and pulse loaded before the mode is switched on
		wr16(tpw_pkg::OFS_CMP2_HI, c2[15:0]);
		wr16(tpw_pkg::OFS_CMP1_HI, c1[15:0]);
		wb(1'b1, tpw_pkg::OFS_CTRL_A, 8'h81, q);
		for (int i = 0; i < 4; i++)
		begin
			// Pin enable, single pulse and PWM together; external clock on rising edges
			wb(1'b1, tpw_pkg::OFS_CTRL_B, {4'hb, codes[i], 2'b01}, q);
			wait_rises(3);
			`CHK(per, exp_period(divs[i], c2))
			`CHK(hi, exp_high(divs[i], c1, c2))
		end
		wb(1'b0, tpw_pkg::OFS_STATUS, 8'h00, q);
		`CHK(q & 8'hc8, 8'h80)
		`CHK(irq, 1'b1)
		wt <= 1'b1;
		@(posedge clk);
		`CHK(wake, 1'b1)
		hlt <= 1'b1;
		@(posedge clk);
		`CHK(wake, 1'b0)
		wb(1'b0, tpw_pkg::OFS_CNT_LO, 8'h00, v);
		repeat (20) @(posedge clk);
		wb(1'b0, tpw_pkg::OFS_CNT_LO, 8'h00, q);
		`CHK(q, v)
		hlt <= 1'b0;
		wt <= 1'b0;
		mask <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		`CHK(irq, 1'b0)
		mask <= 1'b0;
		wb(1'b1, tpw_pkg::OFS_CTRL_A, 8'h05, q);
		@(posedge clk);
		`CHK(irq, 1'b0)
		repeat (exp_period(16, c2)) @(posedge clk);
		st = rises;
		repeat (exp_period(16, c2)) @(posedge clk);
		`CHK(rises, st)
		`CHK(lvl, 1'b1)
		// Capture pin A is cut off in PWM, pin B still captures
		wb(1'b0, tpw_pkg::OFS_CAP1_LO, 8'h00, v);
		cap_a <= 1'b1;
		cap_b <= 1'b1;
		repeat (4) @(posedge clk);
		cap_a <= 1'b0;
		cap_b <= 1'b0;
		repeat (6) @(posedge clk);
		wb(1'b0, tpw_pkg::OFS_CAP1_LO, 8'h00, q);
		`CHK(q, v)
		wb(1'b0, tpw_pkg::OFS_STATUS, 8'h00, q);
		`CHK(q[4], 1'b1)
		wb(1'b1, tpw_pkg::OFS_CTRL_B, 8'h00, q);
		@(posedge clk);
		`CHK(pin_a_oe, 1'b0)
		`CHK(lvl, 1'b0)
		wb(1'b0, tpw_pkg::OFS_STATUS, 8'h00, q);
		wb(1'b0, tpw_pkg::OFS_CAP2_LO, 8'h00, q);
		wb(1'b0, tpw_pkg::OFS_STATUS, 8'h00, q);
		`CHK(q[4], 1'b0)
		wb(1'b0, 8'h3c, 8'h00, q);
		`CHK(q, 8'h00)
		// High byte alone keeps compare one quiet past its new value
		wb(1'b0, tpw_pkg::OFS_CNT_HI, 8'h00, v);
		wb(1'b1, tpw_pkg::OFS_CMP1_HI, v + 8'h01, q);
		wb(1'b0, tpw_pkg::OFS_STATUS, 8'h00, q);
		wb(1'b0, tpw_pkg::OFS_CMP1_LO, 8'h00, q);
		repeat (1200) @(posedge clk);
		wb(1'b0, tpw_pkg::OFS_STATUS, 8'h00, q);
		`CHK(q[6], 1'b0)
		// Capture edge in halt only arms; exit captures the frozen count
		hlt <= 1'b1;
		cap_b <= 1'b1;
		repeat (4) @(posedge clk);
		cap_b <= 1'b0;
		repeat (6) @(posedge clk);
		wb(1'b0, tpw_pkg::OFS_STATUS, 8'h00, q);
		`CHK(q[4], 1'b0)
		wb(1'b0, tpw_pkg::OFS_CNT_LO, 8'h00, v);
		hlt <= 1'b0;
		repeat (2) @(posedge clk);
		wb(1'b0, tpw_pkg::OFS_STATUS, 8'h00, q);
		`CHK(q[4], 1'b1)
		wb(1'b0, tpw_pkg::OFS_CAP2_LO, 8'h00, q);
		`CHK(q, v)
		end_of_test();
	end
endmodule : tpw_timer_tb_top

// ==== verilog/tpw_pkg.sv ====
// Constants and state carrier types for the 16-bit timer PWM block.
// Assumes a byte-addressed classic Wishbone bus with 32-bit data words.
package tpw_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL_A      = 8'h00;
	localparam logic [7:0] OFS_CTRL_B      = 8'h04;
	localparam logic [7:0] OFS_STATUS      = 8'h08;
	localparam logic [7:0] OFS_CMP1_HI     = 8'h0c;
	localparam logic [7:0] OFS_CMP1_LO     = 8'h10;
	localparam logic [7:0] OFS_CMP2_HI     = 8'h14;
	localparam logic [7:0] OFS_CMP2_LO     = 8'h18;
	localparam logic [7:0] OFS_CNT_HI      = 8'h1c;
	localparam logic [7:0] OFS_CNT_LO      = 8'h20;
	localparam logic [7:0] OFS_ALT_HI      = 8'h24;
	localparam logic [7:0] OFS_ALT_LO      = 8'h28;
	localparam logic [7:0] OFS_CAP1_HI     = 8'h2c;
	localparam logic [7:0] OFS_CAP1_LO     = 8'h30;
	localparam logic [7:0] OFS_CAP2_HI     = 8'h34;
	localparam logic [7:0] OFS_CAP2_LO     = 8'h38;

	// Control A fields
	localparam int CA_CAPTURE_IRQ_ENABLE  = 7;
	localparam int CA_MATCH_IRQ_ENABLE    = 6;
	localparam int CA_OVERFLOW_IRQ_ENABLE = 5;
	localparam int CA_FORCE_LEVEL_B       = 4;
	localparam int CA_FORCE_LEVEL_A       = 3;
	localparam int CA_LEVEL_AFTER_MATCH_B = 2;
	localparam int CA_CAPTURE_EDGE_A      = 1;
	localparam int CA_LEVEL_AFTER_MATCH_A = 0;

	// Control B fields
	localparam int CB_PIN_A_ENABLE        = 7;
	localparam int CB_PIN_B_ENABLE        = 6;
	localparam int CB_SINGLE_PULSE        = 5;
	localparam int CB_PWM                 = 4;
	localparam int CB_CLOCK_SEL_HI        = 3;
	localparam int CB_CLOCK_SEL_LO        = 2;
	localparam int CB_CAPTURE_EDGE_B      = 1;
	localparam int CB_EXT_EDGE            = 0;

	// Status fields; flags kept as flg[4:0] = status[7:3]
	localparam int ST_FLAG_LSB            = 3;
	localparam int ST_TIMER_DISABLE       = 2;
	localparam int FL_CAPTURE_A           = 4;
	localparam int FL_MATCH_A             = 3;
	localparam int FL_OVERFLOW            = 2;
	localparam int FL_CAPTURE_B           = 1;
	localparam int FL_MATCH_B             = 0;

	// Reset values and fixed counts
	localparam logic [7:0]  RST_CTRL_A    = 8'h00;
	localparam logic [7:0]  RST_CTRL_B    = 8'h00;
	localparam logic [15:0] RST_COMPARE   = 16'h8000;
	localparam logic [15:0] RST_COUNTER   = 16'hfffc;
	localparam logic [15:0] CNT_RELOAD    = 16'hfffc;
	localparam logic [15:0] CAP_PULSE_VAL = 16'hfffd;
	localparam logic [15:0] CNT_TOP       = 16'hffff;

	// Timer clock selection codes
	localparam logic [1:0] CLK_DIV4       = 2'h0;
	localparam logic [1:0] CLK_DIV2       = 2'h1;
	localparam logic [1:0] CLK_DIV8       = 2'h2;
	localparam logic [1:0] CLK_EXT        = 2'h3;
	localparam logic [2:0] PRESC_MASK4    = 3'h3;
	localparam logic [2:0] PRESC_MASK2    = 3'h1;
	localparam logic [2:0] PRESC_MASK8    = 3'h7;

	typedef struct packed {
		logic [7:0]  ctrl_a;
		logic [7:0]  ctrl_b;
		logic        timer_off;
		logic [4:0]  flg;
		logic [4:0]  arm;
		logic [15:0] cnt;
		logic [2:0]  presc;
		logic [15:0] cmp1_wr;
		logic [15:0] cmp2_wr;
		logic [15:0] cmp1_act;
		logic [15:0] cmp2_act;
		logic [1:0]  cmp_hold;
		logic [15:0] cap1;
		logic [15:0] cap2;
		logic        pin_a;
		logic        pin_b;
		logic [1:0]  halt_arm;
		logic        halt_d;
		logic        ack;
		logic [7:0]  dat;
		logic        cap_a_m;
		logic        cap_a_s;
		logic        cap_a_p;
		logic        cap_b_m;
		logic        cap_b_s;
		logic        cap_b_p;
		logic        ext_m;
		logic        ext_s;
		logic        ext_p;
	} tpw_state_t;

endpackage : tpw_pkg

// ==== verilog/tpw_timer.sv ====
// 16-bit timer with PWM mode, captures, compares and shared interrupt.
// Assumes a classic Wishbone master on CLK_SYS and asynchronous pins.
//
// Register access over Wishbone and the placing of the registers were chosen for this implementation.

module tpw_timer (
	// Clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        RST_B,
	// Wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// Timer pins
	input  wire logic        CAPTURE_IN_PIN_A,
	input  wire logic        CAPTURE_IN_PIN_B,
	input  wire logic        EXT_TIMER_CLK,
	output logic             COMPARE_OUT_PIN_A,
	output logic             COMPARE_OUT_PIN_A_OE,
	output logic             COMPARE_OUT_PIN_B,
	output logic             COMPARE_OUT_PIN_B_OE,
	// Core power and interrupt
	input  wire logic        CPU_IRQ_MASK,
	input  wire logic        WAIT_MODE,
	input  wire logic        HALT_MODE,
	output logic             TIMER_IRQ,
	output logic             WAIT_WAKE_REQ
);

	tpw_pkg::tpw_state_t s_r;
	tpw_pkg::tpw_state_t s_nxt;

	logic       acc;
	logic       wr;
	logic       rd;
	logic [7:0] wd;
	logic       pwm;
	logic       single_pulse_enable;
	logic       run;
	logic       tick;
	logic       edge_a;
	logic       edge_b;
	logic       ext_edge;
	logic       m1;
	logic       m2;
	logic       wake;
	logic [4:0] set;
	logic [4:0] clr_acc;
	logic [4:0] clr;
	logic [2:0] pmask;

	always_comb
	begin
		s_nxt    = s_r;
		set      = 5'h00;
		clr_acc  = 5'h00;
		clr      = 5'h00;
		pmask    = tpw_pkg::PRESC_MASK4;
		tick     = 1'b0;
		acc      = WB_CYC_I & WB_STB_I & ~s_r.ack;
		wr       = acc & WB_WE_I & WB_SEL_I[0];
		rd       = acc & ~WB_WE_I;
		wd       = WB_DAT_I[7:0];
		s_nxt.ack = acc;

		// Two-stage synchronisers, edge detect on second stage only
		s_nxt.cap_a_m = CAPTURE_IN_PIN_A;
		s_nxt.cap_a_s = s_r.cap_a_m;
		s_nxt.cap_a_p = s_r.cap_a_s;
		s_nxt.cap_b_m = CAPTURE_IN_PIN_B;
		s_nxt.cap_b_s = s_r.cap_b_m;
		s_nxt.cap_b_p = s_r.cap_b_s;
		s_nxt.ext_m   = EXT_TIMER_CLK;
		s_nxt.ext_s   = s_r.ext_m;
		s_nxt.ext_p   = s_r.ext_s;
		edge_a   = (s_r.cap_a_s != s_r.cap_a_p)
			& (s_r.cap_a_s == s_r.ctrl_a[tpw_pkg::CA_CAPTURE_EDGE_A]);
		edge_b   = (s_r.cap_b_s != s_r.cap_b_p)
			& (s_r.cap_b_s == s_r.ctrl_b[tpw_pkg::CB_CAPTURE_EDGE_B]);
		ext_edge = (s_r.ext_s != s_r.ext_p)
			& (s_r.ext_s == s_r.ctrl_b[tpw_pkg::CB_EXT_EDGE]);

		pwm = s_r.ctrl_b[tpw_pkg::CB_PWM];
		single_pulse_enable = s_r.ctrl_b[tpw_pkg::CB_SINGLE_PULSE] & ~pwm;

		// Wait leaves the timer alone; halt and disable freeze it
		run = ~HALT_MODE & ~s_r.timer_off;
		s_nxt.halt_d = HALT_MODE;
		wake = s_r.halt_d & ~HALT_MODE;

		// Prescaler and tick select
		if (run)
			s_nxt.presc = s_r.presc + 3'h1;
		unique case (s_r.ctrl_b[tpw_pkg::CB_CLOCK_SEL_HI:tpw_pkg::CB_CLOCK_SEL_LO])
			tpw_pkg::CLK_DIV4: pmask = tpw_pkg::PRESC_MASK4;
			tpw_pkg::CLK_DIV2: pmask = tpw_pkg::PRESC_MASK2;
			tpw_pkg::CLK_DIV8: pmask = tpw_pkg::PRESC_MASK8;
			tpw_pkg::CLK_EXT:  pmask = tpw_pkg::PRESC_MASK8;
		endcase
		if (s_r.ctrl_b[tpw_pkg::CB_CLOCK_SEL_HI:tpw_pkg::CB_CLOCK_SEL_LO] == tpw_pkg::CLK_EXT)
			tick = run & ext_edge;
		else
			tick = run & ((s_r.presc & pmask) == pmask);

		// Compare matches, suspended between high and low byte writes
		m1 = tick & ~s_r.cmp_hold[0] & (s_r.cnt == s_r.cmp1_act);
		m2 = tick & ~s_r.cmp_hold[1] & (s_r.cnt == s_r.cmp2_act);

		// Counter
		if (tick)
		begin
			if (pwm && m2)
				s_nxt.cnt = tpw_pkg::CNT_RELOAD;
			else
			begin
				s_nxt.cnt = s_r.cnt + 16'h0001;
				if (s_r.cnt == tpw_pkg::CNT_TOP)
					set[tpw_pkg::FL_OVERFLOW] = 1'b1;
			end
		end

		// Output and flag behaviour per mode
		if (pwm)
		begin
			if (m2)
			begin
				s_nxt.pin_a = s_r.ctrl_a[tpw_pkg::CA_LEVEL_AFTER_MATCH_B];
				set[tpw_pkg::FL_CAPTURE_A] = 1'b1;
			end
			else if (m1)
				s_nxt.pin_a = s_r.ctrl_a[tpw_pkg::CA_LEVEL_AFTER_MATCH_A];
		end
		else if (single_pulse_enable)
		begin
			if (edge_a && run)
			begin
				s_nxt.cnt   = tpw_pkg::CNT_RELOAD;
				s_nxt.pin_a = s_r.ctrl_a[tpw_pkg::CA_LEVEL_AFTER_MATCH_B];
				s_nxt.cap1  = tpw_pkg::CAP_PULSE_VAL;
				set[tpw_pkg::FL_CAPTURE_A] = 1'b1;
			end
			else if (m1)
				s_nxt.pin_a = s_r.ctrl_a[tpw_pkg::CA_LEVEL_AFTER_MATCH_A];
			if (m2)
				set[tpw_pkg::FL_MATCH_B] = 1'b1;
		end
		else
		begin
			if (m1)
			begin
				set[tpw_pkg::FL_MATCH_A] = 1'b1;
				s_nxt.pin_a = s_r.ctrl_a[tpw_pkg::CA_LEVEL_AFTER_MATCH_A];
			end
			else if (s_r.ctrl_a[tpw_pkg::CA_FORCE_LEVEL_A])
				s_nxt.pin_a = s_r.ctrl_a[tpw_pkg::CA_LEVEL_AFTER_MATCH_A];
			if (m2)
			begin
				set[tpw_pkg::FL_MATCH_B] = 1'b1;
				s_nxt.pin_b = s_r.ctrl_a[tpw_pkg::CA_LEVEL_AFTER_MATCH_B];
			end
			else if (s_r.ctrl_a[tpw_pkg::CA_FORCE_LEVEL_B])
				s_nxt.pin_b = s_r.ctrl_a[tpw_pkg::CA_LEVEL_AFTER_MATCH_B];
		end

		// Input captures; pin A is cut off in PWM and used as trigger in single pulse
		if (HALT_MODE)
		begin
			if (edge_a && !pwm && !single_pulse_enable)
				s_nxt.halt_arm[0] = 1'b1;
			if (edge_b)
				s_nxt.halt_arm[1] = 1'b1;
		end
		else
		begin
			if (edge_a && !pwm && !single_pulse_enable)
			begin
				s_nxt.cap1 = s_r.cnt;
				set[tpw_pkg::FL_CAPTURE_A] = 1'b1;
			end
			if (edge_b)
			begin
				s_nxt.cap2 = s_r.cnt;
				set[tpw_pkg::FL_CAPTURE_B] = 1'b1;
			end
		end
		if (wake)
		begin
			if (s_r.halt_arm[0])
			begin
				s_nxt.cap1 = s_r.cnt;
				set[tpw_pkg::FL_CAPTURE_A] = 1'b1;
			end
			if (s_r.halt_arm[1])
			begin
				s_nxt.cap2 = s_r.cnt;
				set[tpw_pkg::FL_CAPTURE_B] = 1'b1;
			end
			s_nxt.halt_arm = 2'h0;
		end

		// PWM mode suppresses both match flags
		if (pwm)
			set[tpw_pkg::FL_MATCH_A] = 1'b0;
		if (pwm)
			set[tpw_pkg::FL_MATCH_B] = 1'b0;

		// Register writes and low-byte accesses
		if (wr)
		begin
			unique case (WB_ADR_I)
				tpw_pkg::OFS_CTRL_A:  s_nxt.ctrl_a = wd;
				tpw_pkg::OFS_CTRL_B:  s_nxt.ctrl_b = wd;
				tpw_pkg::OFS_STATUS:  s_nxt.timer_off = wd[tpw_pkg::ST_TIMER_DISABLE];
				tpw_pkg::OFS_CMP1_HI:
				begin
					s_nxt.cmp1_wr[15:8] = wd;
					s_nxt.cmp_hold[0]   = 1'b1;
				end
				tpw_pkg::OFS_CMP1_LO:
				begin
					s_nxt.cmp1_wr[7:0] = wd;
					s_nxt.cmp_hold[0]  = 1'b0;
				end
				tpw_pkg::OFS_CMP2_HI:
				begin
					s_nxt.cmp2_wr[15:8] = wd;
					s_nxt.cmp_hold[1]   = 1'b1;
				end
				tpw_pkg::OFS_CMP2_LO:
				begin
					s_nxt.cmp2_wr[7:0] = wd;
					s_nxt.cmp_hold[1]  = 1'b0;
				end
				default: ;
			endcase
		end
		if (acc)
		begin
			unique case (WB_ADR_I)
				tpw_pkg::OFS_CAP1_LO: clr_acc[tpw_pkg::FL_CAPTURE_A] = 1'b1;
				tpw_pkg::OFS_CMP1_LO: clr_acc[tpw_pkg::FL_MATCH_A]   = 1'b1;
				tpw_pkg::OFS_CNT_LO:  clr_acc[tpw_pkg::FL_OVERFLOW]  = 1'b1;
				tpw_pkg::OFS_CAP2_LO: clr_acc[tpw_pkg::FL_CAPTURE_B] = 1'b1;
				tpw_pkg::OFS_CMP2_LO: clr_acc[tpw_pkg::FL_MATCH_B]   = 1'b1;
				default: ;
			endcase
		end

		// Double buffering: in PWM only the period end loads new values
		if (!pwm || m2)
		begin
			s_nxt.cmp1_act = s_nxt.cmp1_wr;
			s_nxt.cmp2_act = s_nxt.cmp2_wr;
		end

		// Flag clear sequence; a same-cycle set wins
		clr = s_r.arm & clr_acc;
		s_nxt.flg = (s_r.flg & ~clr) | set;
		if (rd && WB_ADR_I == tpw_pkg::OFS_STATUS)
			s_nxt.arm = s_r.flg;
		else
			s_nxt.arm = s_r.arm & ~clr;

		// Read data
		if (rd)
		begin
			unique case (WB_ADR_I)
				tpw_pkg::OFS_CTRL_A:  s_nxt.dat = s_r.ctrl_a;
				tpw_pkg::OFS_CTRL_B:  s_nxt.dat = s_r.ctrl_b;
				tpw_pkg::OFS_STATUS:
					s_nxt.dat = {s_r.flg, s_r.timer_off, 2'h0};
				tpw_pkg::OFS_CMP1_HI: s_nxt.dat = s_r.cmp1_wr[15:8];
				tpw_pkg::OFS_CMP1_LO: s_nxt.dat = s_r.cmp1_wr[7:0];
				tpw_pkg::OFS_CMP2_HI: s_nxt.dat = s_r.cmp2_wr[15:8];
				tpw_pkg::OFS_CMP2_LO: s_nxt.dat = s_r.cmp2_wr[7:0];
				tpw_pkg::OFS_CNT_HI:  s_nxt.dat = s_r.cnt[15:8];
				tpw_pkg::OFS_CNT_LO:  s_nxt.dat = s_r.cnt[7:0];
				tpw_pkg::OFS_ALT_HI:  s_nxt.dat = s_r.cnt[15:8];
				tpw_pkg::OFS_ALT_LO:  s_nxt.dat = s_r.cnt[7:0];
				tpw_pkg::OFS_CAP1_HI: s_nxt.dat = s_r.cap1[15:8];
				tpw_pkg::OFS_CAP1_LO: s_nxt.dat = s_r.cap1[7:0];
				tpw_pkg::OFS_CAP2_HI: s_nxt.dat = s_r.cap2[15:8];
				tpw_pkg::OFS_CAP2_LO: s_nxt.dat = s_r.cap2[7:0];
				default:              s_nxt.dat = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			s_r          <= '0;
			s_r.ctrl_a   <= tpw_pkg::RST_CTRL_A;
			s_r.ctrl_b   <= tpw_pkg::RST_CTRL_B;
			s_r.cnt      <= tpw_pkg::RST_COUNTER;
			s_r.cmp1_wr  <= tpw_pkg::RST_COMPARE;
			s_r.cmp2_wr  <= tpw_pkg::RST_COMPARE;
			s_r.cmp1_act <= tpw_pkg::RST_COMPARE;
			s_r.cmp2_act <= tpw_pkg::RST_COMPARE;
		end
		else
			s_r <= s_nxt;
	end

	// Bus outputs
	assign WB_ACK_O = s_r.ack;
	assign WB_DAT_O = {24'h000000, s_r.dat};

	// Pins: compare logic runs even while the pin is left to general I/O
	assign COMPARE_OUT_PIN_A    = s_r.pin_a;
	assign COMPARE_OUT_PIN_A_OE = s_r.ctrl_b[tpw_pkg::CB_PIN_A_ENABLE] & ~s_r.timer_off;
	assign COMPARE_OUT_PIN_B    = s_r.pin_b;
	assign COMPARE_OUT_PIN_B_OE = s_r.ctrl_b[tpw_pkg::CB_PIN_B_ENABLE] & ~s_r.timer_off
		& ~pwm & ~s_r.ctrl_b[tpw_pkg::CB_SINGLE_PULSE];

	// Shared interrupt
	assign TIMER_IRQ = ~CPU_IRQ_MASK & (
		(s_r.ctrl_a[tpw_pkg::CA_CAPTURE_IRQ_ENABLE]
			& (s_r.flg[tpw_pkg::FL_CAPTURE_A] | s_r.flg[tpw_pkg::FL_CAPTURE_B]))
		| (s_r.ctrl_a[tpw_pkg::CA_MATCH_IRQ_ENABLE]
			& (s_r.flg[tpw_pkg::FL_MATCH_A] | s_r.flg[tpw_pkg::FL_MATCH_B]))
		| (s_r.ctrl_a[tpw_pkg::CA_OVERFLOW_IRQ_ENABLE] & s_r.flg[tpw_pkg::FL_OVERFLOW]));
	assign WAIT_WAKE_REQ = TIMER_IRQ & WAIT_MODE & ~HALT_MODE;

endmodule : tpw_timer
